// file: hw/dcl_pkg.sv
package dcl_pkg;

    // Register byte addresses.
    localparam logic [15:0] ADDR_LATENCY_REPORT_CONTROL     = 16'h01a0;
    localparam logic [15:0] ADDR_COALESCING_PAUSE_WATERMARK = 16'h2170;
    localparam logic [15:0] ADDR_COALESCING_CONTROL         = 16'h2508;
    localparam logic [15:0] ADDR_LOW_POWER_REQUEST_DELAY    = 16'h2514;
    localparam logic [15:0] ADDR_COALESCING_TX_THRESHOLD    = 16'h3550;
    localparam logic [15:0] ADDR_LATENCY_MINIMUM_VALUES     = 16'h5bb0;
    localparam logic [15:0] ADDR_LATENCY_MAXIMUM_VALUES     = 16'h5bb4;
    localparam logic [15:0] ADDR_RATE_WINDOW_CONTROL        = 16'h5db0;
    localparam logic [15:0] ADDR_BASIC_INTERVAL             = 16'h5dcc;
    localparam logic [15:0] ADDR_RX_RATE_THRESHOLD          = 16'h5dd0;
    localparam logic [15:0] ADDR_RX_RATE_CURRENT_COUNT      = 16'h5dd4;

    // Values after reset.
    localparam logic [1:0]  IDLE_LINK_STATE_RST = 2'h2;
    localparam logic [11:0] TX_THRESHOLD_RST    = 12'he4;
    localparam logic [9:0]  TOL_VALUE_RST       = 10'h005;
    localparam logic [2:0]  TOL_SCALE_RST       = 3'h3;
    localparam logic [9:0]  WINDOW_LEN_RST      = 10'h008;
    localparam logic [24:0] BASIC_INTERVAL_RST  = 25'h05f5e10;

    // Link state requests towards the host port.
    localparam logic [1:0] LINK_L0  = 2'h0;
    localparam logic [1:0] LINK_L0S = 2'h1;
    localparam logic [1:0] LINK_L1  = 2'h2;

    // Timing: clock period, microsecond and the 16 ns basic step, all in ns.
    localparam int CLK_PERIOD_NS = 5;
    localparam int MICROSEC_NS   = 1000;
    localparam int BASIC_STEP_NS = 16;
    localparam int CYC_PER_US    = (MICROSEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] US_DIV_LAST  = 8'(CYC_PER_US - 1);
    localparam logic [4:0] WD_UNIT_LAST = 5'h1f;  // 32 microseconds per watchdog unit.
    localparam logic [4:0] NS_ADD       = 5'(CLK_PERIOD_NS);
    localparam logic [4:0] NS_WRAP      = 5'(BASIC_STEP_NS);

    // Basic interval steps per 16 ns at 10, 100 and 1000 Mb/s.
    localparam logic [25:0] STEP_10M   = 26'h0000001;
    localparam logic [25:0] STEP_100M  = 26'h000000a;
    localparam logic [25:0] STEP_1000M = 26'h0000064;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_WAIT = 3'b010,
        ST_COAL = 3'b100
    } dcl_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dcl_bus_req_t;

    typedef struct packed {
        logic       snp_req;
        logic       nsnp_req;
        logic [2:0] scale;
        logic [9:0] value;
    } dcl_tol_t;

    typedef struct packed {
        logic [15:0] snoop;
        logic [15:0] no_snoop;
    } dcl_ltr_msg_t;

    typedef struct packed {
        dcl_state_t   st;
        logic [13:0]  wd_limit;
        logic [7:0]   rx_thr;
        logic [1:0]   lx_sel;
        logic         coal_en;
        logic [11:0]  tx_thr;
        logic [11:0]  lp_delay;
        logic [18:0]  rate_thr;
        logic         low_rate;
        logic [24:0]  rate_cnt;
        logic [13:0]  pause_wm;
        dcl_tol_t     tol_min;
        dcl_tol_t     tol_max;
        logic         send_min;
        logic         send_max;
        logic         pd_en;
        logic         ld_en;
        logic [9:0]   win_len;
        logic [24:0]  basic_int;
        logic [7:0]   us_div;
        logic         us_tick;
        logic [4:0]   wd_div;
        logic [4:0]   ns_acc;
        logic [25:0]  bi_cnt;
        logic [9:0]   win_cnt;
        logic [11:0]  dly_cnt;
        logic [13:0]  wd_cnt;
        logic [3:0]   prev_src;
        logic [3:0]   pend;
        logic         xoff_prev;
        logic [31:0]  rdata;
        logic         coal_active;
        logic [1:0]   link_req;
        logic         xoff;
        logic         ltr_send;
        dcl_ltr_msg_t ltr_msg;
    } dcl_regs_t;

endpackage

// file: hw/dcl_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// Notes on behaviour
// - Watchdog bounds pending work delay, 32 us units.
// - Receive buffer above threshold ends coalescing.
// - Idle link state selects L0, L0s or L1.
// - Coalescing only while enable bit is one.
// - Free transmit space plus pending data ends coalescing.
// - Zero transmit threshold disables transmit exit.
// - Wait programmed microseconds before low-power request.
// - Low receive rate forbids entering coalescing.
// - Status bit shows receive rate below threshold.
// - Rate counter saturates at threshold, never wraps.
// - Pause frame on coalescing, empty FIFO, flow control enable, watermark.
// - Tolerance is value times selected scale.
// - Same tolerance reported for snoop and no-snoop.
// - Requirement bits say whether tolerance applies.
// - Send-minimum rising sends minimum tolerance message.
// - Send-maximum rising sends maximum tolerance message.
// - Port disable sends message without requirements.
// - Link disconnect sends message without requirements.
// - Rate window counts basic intervals, write restarts.
// - Basic interval in 16 ns, scaled by speed.
module dcl_top
    import dcl_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire dcl_bus_req_t bus_req,
    output logic [31:0]       bus_rdata,
    input  wire logic [15:0]  rx_buf_used,
    input  wire logic [11:0]  tx_buf_free,
    input  wire logic         tx_data_waiting,
    input  wire logic         tx_fifo_empty,
    input  wire logic         tx_flow_control_enable,
    input  wire logic         rx_chunk,
    input  wire logic         service_pending,
    input  wire logic         host_idle,
    input  wire logic [1:0]   link_speed,
    input  wire logic         port_disabled,
    input  wire logic         link_disconnected,
    output logic              coalescing_active,
    output logic [1:0]        link_state_req,
    output logic              xoff_req,
    output logic              ltr_send,
    output dcl_ltr_msg_t      ltr_msg
);

    dcl_regs_t s;
    dcl_regs_t n;

    // Maps the idle link-state field; the reserved code keeps the link in L0.
    function automatic logic [1:0] idle_target(input logic [1:0] sel);
        logic [1:0] t;
        t = LINK_L0;
        case (sel)
            2'h1: t = LINK_L0S;
            2'h2: t = LINK_L1;
            default: t = LINK_L0;
        endcase
        return t;
    endfunction

    // Builds one half of a tolerance message from a stored value set.
    function automatic logic [15:0] tol_word(input logic req, input dcl_tol_t v);
        return {req, 2'h0, v.scale, v.value};
    endfunction

    logic [4:0]  ns_sum;
    logic        step16;
    logic [25:0] bi_step;
    logic [25:0] bi_sum;
    logic        win_end;
    logic        rx_exit;
    logic        tx_exit;
    logic        wd_exit;
    logic        enter_ok;
    logic        xoff_cond;
    logic [3:0]  src_now;
    logic [3:0]  pend_all;

    // Next-state logic for the whole block.
    always_comb begin
        ns_sum    = 5'h00;
        step16    = 1'b0;
        bi_step   = STEP_10M;
        bi_sum    = 26'h0;
        win_end   = 1'b0;
        rx_exit   = 1'b0;
        tx_exit   = 1'b0;
        wd_exit   = 1'b0;
        enter_ok  = 1'b0;
        xoff_cond = 1'b0;
        src_now   = 4'h0;
        pend_all  = 4'h0;
        n         = s;
        n.us_tick = 1'b0;
        n.xoff    = 1'b0;
        n.ltr_send = 1'b0;
        n.rdata   = 32'h0;

        // Microsecond timebase and the 32 microsecond watchdog unit.
        if (s.us_div == US_DIV_LAST) begin
            n.us_div  = 8'h00;
            n.us_tick = 1'b1;
        end else begin
            n.us_div = s.us_div + 8'h01;
        end

        // 16 ns steps from a 5 ns clock by a fractional accumulator, so the long-run rate is exact.
        ns_sum = s.ns_acc + NS_ADD;
        if (ns_sum >= NS_WRAP) begin
            step16   = 1'b1;
            n.ns_acc = ns_sum - NS_WRAP;
        end else begin
            n.ns_acc = ns_sum;
        end

        // Faster links advance the interval by more per step instead of dividing the count.
        case (link_speed)
            2'h1: bi_step = STEP_100M;
            2'h2: bi_step = STEP_1000M;
            default: bi_step = STEP_10M;
        endcase
        bi_sum = s.bi_cnt + bi_step;
        if (step16) begin
            if (bi_sum >= {1'b0, s.basic_int}) begin
                n.bi_cnt = 26'h0;
                if (s.win_cnt + 10'h001 >= s.win_len) begin
                    n.win_cnt = 10'h000;
                    win_end   = 1'b1;
                end else begin
                    n.win_cnt = s.win_cnt + 10'h001;
                end
            end else begin
                n.bi_cnt = bi_sum;
            end
        end

        // Receive rate count, saturating at the threshold, and the window verdict.
        if (win_end) begin
            n.low_rate = (s.rate_cnt < {6'h00, s.rate_thr});
            n.rate_cnt = 25'h0;
        end else if (rx_chunk && (s.rate_cnt < {6'h00, s.rate_thr})) begin
            n.rate_cnt = s.rate_cnt + 25'h1;
        end

        // Exit conditions while coalescing or waiting to coalesce.
        rx_exit  = rx_buf_used > {2'h0, s.rx_thr, 6'h00};
        tx_exit  = (s.tx_thr != 12'h0) && (tx_buf_free > s.tx_thr) && tx_data_waiting;
        wd_exit  = service_pending && (s.wd_cnt >= s.wd_limit);
        enter_ok = s.coal_en && host_idle && !s.low_rate && !rx_exit && !tx_exit;

        // Watchdog counts 32 microsecond units only while work is pending.
        if (!service_pending || s.st == ST_RUN) begin
            n.wd_div = 5'h00;
            n.wd_cnt = 14'h0;
        end else if (s.us_tick) begin
            n.wd_div = s.wd_div + 5'h01;
            if (s.wd_div == WD_UNIT_LAST && s.wd_cnt != 14'h3fff) begin
                n.wd_cnt = s.wd_cnt + 14'h0001;
            end
        end

        // Coalescing sequence: run, delay before the low-power request, coalesce.
        case (s.st)
            ST_RUN: begin
                n.coal_active = 1'b0;
                n.dly_cnt     = 12'h0;
                if (s.coal_en) begin
                    n.link_req = LINK_L0;
                    if (enter_ok) begin
                        n.st = ST_WAIT;
                    end
                end else begin
                    n.link_req = host_idle ? idle_target(s.lx_sel) : LINK_L0;
                end
            end
            ST_WAIT: begin
                if (!enter_ok || wd_exit) begin
                    n.st = ST_RUN;
                end else if (s.dly_cnt >= s.lp_delay) begin
                    n.st          = ST_COAL;
                    n.coal_active = 1'b1;
                    n.link_req    = idle_target(s.lx_sel);
                end else if (s.us_tick) begin
                    n.dly_cnt = s.dly_cnt + 12'h001;
                end
            end
            ST_COAL: begin
                if (!s.coal_en || rx_exit || tx_exit || wd_exit) begin
                    n.st          = ST_RUN;
                    n.coal_active = 1'b0;
                    n.link_req    = LINK_L0;
                end
            end
            default: begin
                n.st          = ST_RUN;
                n.coal_active = 1'b0;
                n.link_req    = LINK_L0;
            end
        endcase

        // One pause frame per rise of the pause condition.
        xoff_cond   = s.coal_active && tx_fifo_empty && tx_flow_control_enable
                      && (rx_buf_used >= {2'h0, s.pause_wm});
        n.xoff_prev = xoff_cond;
        n.xoff      = xoff_cond && !s.xoff_prev;

        // Tolerance messages start on rising edges only; bit 0 disable, 1 disconnect.
        src_now    = {s.send_max, s.send_min, link_disconnected, port_disabled};
        n.prev_src = src_now;
        pend_all   = s.pend | (src_now & ~s.prev_src & {2'b11, s.ld_en, s.pd_en});
        n.pend     = pend_all;
        if (pend_all[0] || pend_all[1]) begin
            n.ltr_send = 1'b1;
            n.ltr_msg  = '{snoop: tol_word(1'b0, s.tol_min), no_snoop: tol_word(1'b0, s.tol_min)};
            if (pend_all[0]) begin
                n.pend[0] = 1'b0;
            end else begin
                n.pend[1] = 1'b0;
            end
        end else if (pend_all[2]) begin
            n.ltr_send = 1'b1;
            n.pend[2]  = 1'b0;
            n.ltr_msg  = '{snoop:    tol_word(s.tol_min.snp_req, s.tol_min),
                           no_snoop: tol_word(s.tol_min.nsnp_req, s.tol_min)};
        end else if (pend_all[3]) begin
            n.ltr_send = 1'b1;
            n.pend[3]  = 1'b0;
            n.ltr_msg  = '{snoop:    tol_word(s.tol_max.snp_req, s.tol_max),
                           no_snoop: tol_word(s.tol_max.nsnp_req, s.tol_max)};
        end

        // Register writes; reserved bits are dropped and read back as zero.
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_COALESCING_CONTROL: begin
                    n.wd_limit = bus_req.wdata[13:0];
                    n.rx_thr   = bus_req.wdata[23:16];
                    n.lx_sel   = bus_req.wdata[29:28];
                    n.coal_en  = bus_req.wdata[31];
                end
                ADDR_COALESCING_TX_THRESHOLD: n.tx_thr   = bus_req.wdata[11:0];
                ADDR_LOW_POWER_REQUEST_DELAY: n.lp_delay = bus_req.wdata[11:0];
                ADDR_RX_RATE_THRESHOLD:       n.rate_thr = bus_req.wdata[18:0];
                ADDR_COALESCING_PAUSE_WATERMARK: n.pause_wm = bus_req.wdata[17:4];
                ADDR_LATENCY_MINIMUM_VALUES: begin
                    n.tol_min = '{snp_req: bus_req.wdata[15], nsnp_req: bus_req.wdata[31],
                                  scale: bus_req.wdata[12:10], value: bus_req.wdata[9:0]};
                end
                ADDR_LATENCY_MAXIMUM_VALUES: begin
                    n.tol_max = '{snp_req: bus_req.wdata[15], nsnp_req: bus_req.wdata[31],
                                  scale: bus_req.wdata[12:10], value: bus_req.wdata[9:0]};
                end
                ADDR_LATENCY_REPORT_CONTROL: begin
                    n.send_min = bus_req.wdata[1];
                    n.send_max = bus_req.wdata[2];
                    n.pd_en    = bus_req.wdata[3];
                    n.ld_en    = bus_req.wdata[4];
                end
                ADDR_RATE_WINDOW_CONTROL: begin
                    n.win_len = bus_req.wdata[17:8];
                    n.win_cnt = 10'h000;
                    n.bi_cnt  = 26'h0;
                end
                ADDR_BASIC_INTERVAL: n.basic_int = bus_req.wdata[24:0];
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses return zero.
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_COALESCING_CONTROL:
                    n.rdata = {s.coal_en, 1'b0, s.lx_sel, 4'h0, s.rx_thr, 2'h0, s.wd_limit};
                ADDR_COALESCING_TX_THRESHOLD:    n.rdata = {20'h0, s.tx_thr};
                ADDR_LOW_POWER_REQUEST_DELAY:    n.rdata = {20'h0, s.lp_delay};
                ADDR_RX_RATE_THRESHOLD:          n.rdata = {s.low_rate, 12'h0, s.rate_thr};
                ADDR_RX_RATE_CURRENT_COUNT:      n.rdata = {7'h00, s.rate_cnt};
                ADDR_COALESCING_PAUSE_WATERMARK: n.rdata = {14'h0, s.pause_wm, 4'h0};
                ADDR_LATENCY_MINIMUM_VALUES:
                    n.rdata = {s.tol_min.nsnp_req, 15'h0, tol_word(s.tol_min.snp_req, s.tol_min)};
                ADDR_LATENCY_MAXIMUM_VALUES:
                    n.rdata = {s.tol_max.nsnp_req, 15'h0, tol_word(s.tol_max.snp_req, s.tol_max)};
                ADDR_LATENCY_REPORT_CONTROL:
                    n.rdata = {27'h0, s.ld_en, s.pd_en, s.send_max, s.send_min, 1'b0};
                ADDR_RATE_WINDOW_CONTROL:        n.rdata = {14'h0, s.win_len, 8'h00};
                ADDR_BASIC_INTERVAL:             n.rdata = {7'h00, s.basic_int};
                default:                         n.rdata = 32'h0;
            endcase
        end

        // Synchronous reset puts every field at its documented starting value.
        if (srst) begin
            n           = '0;
            n.st        = ST_RUN;
            n.lx_sel    = IDLE_LINK_STATE_RST;
            n.tx_thr    = TX_THRESHOLD_RST;
            n.tol_min   = '{snp_req: 1'b0, nsnp_req: 1'b0, scale: TOL_SCALE_RST, value: TOL_VALUE_RST};
            n.tol_max   = '{snp_req: 1'b0, nsnp_req: 1'b0, scale: TOL_SCALE_RST, value: TOL_VALUE_RST};
            n.pd_en     = 1'b1;
            n.ld_en     = 1'b1;
            n.win_len   = WINDOW_LEN_RST;
            n.basic_int = BASIC_INTERVAL_RST;
            n.link_req  = LINK_L0;
        end
    end

    // The whole state advances on one edge.
    always_ff @(posedge ref_clk) begin
        s <= n;
    end

    // Outputs come straight from the state flops.
    assign bus_rdata         = s.rdata;
    assign coalescing_active = s.coal_active;
    assign link_state_req    = s.link_req;
    assign xoff_req          = s.xoff;
    assign ltr_send          = s.ltr_send;
    assign ltr_msg           = s.ltr_msg;

    // Checks on the coalescing sequence, pause frames and tolerance messages.
    a_enable_gates_coal: assert property (@(posedge ref_clk) disable iff (srst)
        !s.coal_en |=> !coalescing_active)
        else $error("coalescing active with enable clear");

    a_rx_threshold_exit: assert property (@(posedge ref_clk) disable iff (srst)
        (s.st == ST_COAL) && rx_exit |=> !coalescing_active && (link_state_req == LINK_L0))
        else $error("receive threshold did not end coalescing");

    a_tx_threshold_exit: assert property (@(posedge ref_clk) disable iff (srst)
        (s.st == ST_COAL) && (s.tx_thr != 12'h0) && (tx_buf_free > s.tx_thr) && tx_data_waiting
        |=> (s.st == ST_RUN) && (link_state_req == LINK_L0))
        else $error("transmit threshold did not end coalescing");

    a_idle_link_state: assert property (@(posedge ref_clk) disable iff (srst)
        (s.st == ST_RUN) && !s.coal_en && host_idle && (s.lx_sel == 2'h2) && !bus_req.wr
        |=> link_state_req == LINK_L1)
        else $error("idle link state not followed");

    a_low_rate_block: assert property (@(posedge ref_clk) disable iff (srst)
        (s.st == ST_RUN) && s.low_rate |=> s.st != ST_WAIT)
        else $error("coalescing entered at low receive rate");

    a_delay_respected: assert property (@(posedge ref_clk) disable iff (srst)
        (s.st == ST_WAIT) ##1 (s.st == ST_COAL) |-> $past(s.dly_cnt) >= $past(s.lp_delay))
        else $error("low-power request before delay elapsed");

    a_count_saturates: assert property (@(posedge ref_clk) disable iff (srst)
        (s.rate_cnt >= {6'h00, s.rate_thr}) && !win_end |=> $stable(s.rate_cnt))
        else $error("rate counter moved past threshold");

    a_xoff_cause: assert property (@(posedge ref_clk) disable iff (srst)
        xoff_req |-> $past(s.coal_active) && $past(tx_fifo_empty)
                     && $past(tx_flow_control_enable)
                     && ($past(rx_buf_used) >= {2'h0, $past(s.pause_wm)}))
        else $error("pause frame without its cause");

    a_min_report_sent: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(s.send_min) && (s.pend == 4'h0) && !port_disabled && !link_disconnected
        |-> ##[1:2] ltr_send)
        else $error("minimum tolerance message not sent");

    a_disable_report: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(port_disabled) && s.pd_en && (s.pend == 4'h0)
        |=> ltr_send && !ltr_msg.snoop[15] && !ltr_msg.no_snoop[15])
        else $error("port disable message wrong or missing");

    a_send_once: assert property (@(posedge ref_clk) disable iff (srst)
        ltr_send && (s.pend == 4'h0) && (src_now == s.prev_src) |=> !ltr_send)
        else $error("tolerance message repeated without new edge");

endmodule

// file: tb/dcl_host_port.sv
`timescale 1ns/10ps
// Upstream port model: each tolerance message keeps the port busy for two
// cycles, so the block sees host traffic and must not start coalescing then.
module dcl_host_port
    import dcl_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic ltr_send,
    output logic      host_idle
);
    logic [1:0] busy_r;
    // Busy counter reloads on every message and runs down to zero.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_r <= 2'h0;
        end else begin
            busy_r <= ltr_send ? 2'h2 : busy_r - {1'b0, busy_r != 2'h0};
        end
    end
    assign host_idle = (busy_r == 2'h0);
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
    import dcl_pkg::*;
    logic         ref_clk = 1'b0;
    logic         srst    = 1'b1;
    dcl_bus_req_t bus_req = '0;
    logic [31:0]  bus_rdata;
    logic [15:0]  rx_buf_used = 16'h0;
    logic         fifo_empty  = 1'b0;
    logic         fc_en       = 1'b0;
    logic         port_dis    = 1'b0;
    logic         link_down   = 1'b0;
    logic [11:0]  tx_free     = 12'h0;
    logic         tx_wait     = 1'b0;
    logic         chunk       = 1'b0;
    logic         pend        = 1'b0;
    logic [1:0]   spd         = 2'h0;
    logic         host_idle;
    logic         coal;
    logic [1:0]   link_req;
    logic         xoff;
    logic         ltr_send;
    dcl_ltr_msg_t ltr_msg;
    int           error_cnt = 0;
    int           n_checks  = 0;

    // Every far-side input but host_idle, which the host port model drives, is a bench register driven at the rising edge.
    dcl_top dcl_top_inst (.ref_clk(ref_clk), .srst(srst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .rx_buf_used(rx_buf_used), .tx_buf_free(tx_free),
        .tx_data_waiting(tx_wait), .tx_fifo_empty(fifo_empty),
        .tx_flow_control_enable(fc_en), .rx_chunk(chunk), .service_pending(pend),
        .host_idle(host_idle), .link_speed(spd), .port_disabled(port_dis),
        .link_disconnected(link_down), .coalescing_active(coal),
        .link_state_req(link_req), .xoff_req(xoff), .ltr_send(ltr_send),
        .ltr_msg(ltr_msg));
    dcl_host_port dcl_host_port_inst (.ref_clk(ref_clk), .srst(srst),
        .ltr_send(ltr_send), .host_idle(host_idle));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle strobes; read data is taken in the single cycle after rd.
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge ref_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) bus_req.wr <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] exp);
        @(posedge ref_clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) bus_req.rd <= 1'b0;
        #1 chk("read data", exp, bus_rdata);
    endtask

    // Exactly one message must appear in the next five cycles.
    task automatic ltr_expect(logic [31:0] exp);
        int          n;
        logic [31:0] m;
        n = 0;
        m = '0;
        repeat (5) begin
            @(posedge ref_clk);
            #1 if (ltr_send === 1'b1) begin
                n++;
                m = ltr_msg;
            end
        end
        chk("message count", 32'h1, n);
        chk("message", exp, m);
    endtask

    task automatic test_reset_values();
        rd(ADDR_COALESCING_CONTROL, 32'h20000000);
        rd(ADDR_COALESCING_TX_THRESHOLD, 32'h000000e4);
        rd(ADDR_LATENCY_MINIMUM_VALUES, 32'h00000c05);
        rd(ADDR_LATENCY_REPORT_CONTROL, 32'h00000018);
        rd(ADDR_RATE_WINDOW_CONTROL, 32'h00000800);
        rd(16'h1234, 32'h0);
    endtask

    task automatic test_ltr();
        wr(ADDR_LATENCY_MINIMUM_VALUES, 32'h80008c0a);
        wr(ADDR_LATENCY_REPORT_CONTROL, 32'h0000001a);
        ltr_expect(32'h8c0a8c0a);
        wr(ADDR_LATENCY_MAXIMUM_VALUES, 32'h00000801);
        wr(ADDR_LATENCY_REPORT_CONTROL, 32'h0000001c);
        ltr_expect(32'h08010801);
        @(posedge ref_clk) port_dis <= 1'b1;
        ltr_expect(32'h0c0a0c0a);
        @(posedge ref_clk) link_down <= 1'b1;
        ltr_expect(32'h0c0a0c0a);
    endtask

    // Enter coalescing, stay under the rx threshold, then jump past it and the watermark.
    task automatic test_coalescing();
        int n;
        n = 0;
        @(posedge ref_clk) fifo_empty <= 1'b1;
        fc_en <= 1'b1;
        wr(ADDR_COALESCING_PAUSE_WATERMARK, 32'h00000960);
        wr(ADDR_COALESCING_CONTROL, 32'ha0020000);
        repeat (40) @(posedge ref_clk);
        #1 chk("coalescing", 32'h1, coal);
        chk("link request", LINK_L1, link_req);
        @(posedge ref_clk) rx_buf_used <= 16'd100;
        repeat (4) begin
            @(posedge ref_clk);
            #1 if (xoff === 1'b1) n++;
        end
        chk("pause pulses", 32'h0, n);
        chk("coalescing", 32'h1, coal);
        @(posedge ref_clk) rx_buf_used <= 16'd150;
        repeat (4) begin
            @(posedge ref_clk);
            #1 if (xoff === 1'b1) n++;
        end
        chk("pause pulses", 32'h1, n);
        chk("coalescing", 32'h0, coal);
        chk("link request", LINK_L0, link_req);
    endtask

    // Long windows at 10 Mb/s, short ones at 1000 Mb/s, threshold of three chunks.
    task automatic test_rate();
        wr(ADDR_BASIC_INTERVAL, 32'h00000100);
        wr(ADDR_RX_RATE_THRESHOLD, 32'h00000003);
        wr(ADDR_RATE_WINDOW_CONTROL, 32'h00000100);
        @(posedge ref_clk) chunk <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chunk <= 1'b0;
        repeat (200) @(posedge ref_clk);
        rd(ADDR_RX_RATE_CURRENT_COUNT, 32'h00000003);
        @(posedge ref_clk) spd <= 2'h2;
        repeat (50) @(posedge ref_clk);
        rd(ADDR_RX_RATE_CURRENT_COUNT, 32'h00000000);
        rd(ADDR_RX_RATE_THRESHOLD, 32'h80000003);
        @(posedge ref_clk) rx_buf_used <= 16'h0;
        repeat (20) @(posedge ref_clk);
        #1 chk("coalescing", 32'h0, coal);
        @(posedge ref_clk) chunk <= 1'b1;
        repeat (40) @(posedge ref_clk);
        #1 chk("coalescing", 32'h1, coal);
    endtask

    // Transmit space exit, its zero-threshold disable, then the watchdog bound.
    task automatic test_exits();
        int n;
        n = 0;
        @(posedge ref_clk) tx_free <= 12'h0ff;
        tx_wait <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk("coalescing", 32'h0, coal);
        chk("link request", LINK_L0, link_req);
        wr(ADDR_COALESCING_TX_THRESHOLD, 32'h00000000);
        repeat (10) @(posedge ref_clk);
        #1 chk("coalescing", 32'h1, coal);
        wr(ADDR_COALESCING_CONTROL, 32'ha0020001);
        @(posedge ref_clk) pend <= 1'b1;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (coal === 1'b1 && n < 7000);
        chk("watchdog exit", 32'h1, {31'h0, (n > 6100) && (n < 6450)});
        chk("link request", LINK_L0, link_req);
        @(posedge ref_clk) pend <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        test_reset_values();
        test_ltr();
        test_coalescing();
        test_rate();
        test_exits();
        results();
    end

    // The watchdog scenario alone takes some 6,400 cycles; this limit cuts a hang short.
    initial begin
        #100000;
        error_cnt++;
        results();
    end
endmodule
